//--- logic/rcmc_pkg.sv
package rcmc_pkg;

    // Register offsets on the host port
    localparam logic [7:0] CMD_OFFSET = 8'ha4;
    localparam logic [7:0] MODE_OFFSET = 8'ha5;

    // Reset values
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [5:0] MODE_RESET = 6'h04;

    // Width of the implemented part of the mode register
    localparam int MODE_BITS = 6;

    // Command register field positions
    localparam int CMD_GAIN_FREEZE_BIT = 3;
    localparam int CMD_FREQ_FREEZE_BIT = 2;
    localparam int CMD_TIMEOUT_BIT = 1;
    localparam int CMD_MSG_END_BIT = 0;

    // Mode register field positions
    localparam int MODE_NEXT_CFG_BIT = 5;
    localparam int MODE_NEXT_CH_BIT = 4;
    localparam int MODE_CYCLE_CLR_BIT = 3;
    localparam int MODE_FRAME_CLR_BIT = 2;
    localparam int MODE_LOCK_BIT = 1;
    localparam int MODE_XTAL_BIT = 0;

    // External processing selector values that allow forced events
    localparam logic [1:0] EXT_PROC_ONE = 2'h1;
    localparam logic [1:0] EXT_PROC_TWO = 2'h2;

    // First configuration of the polling set
    localparam logic [1:0] CONFIG_A = 2'h0;

    // Operating mode selector: slave run or sleep versus self polling
    localparam logic MODE_SELF_POLL = 1'h1;

    // FIFO lock states, Gray along free to held
    typedef enum logic {
        LK_FREE = 1'h0,
        LK_HELD = 1'h1
    } rcmc_lock_t;

endpackage : rcmc_pkg

//--- logic/rcmc_resume_select.sv
// Picks the configuration at which self polling resumes
module rcmc_resume_select (
    // Polling position
    input wire logic [1:0] currentConfig,
    input wire logic [1:0] configurationSelect,
    // Advance request
    input wire logic advance,
    // Result
    output logic [1:0] nextConfig
);

    // On advance step to the next configuration, wrapping to A after the last selected one; A without advance
    always_comb
    begin
        if (!advance)
        begin
            nextConfig = rcmc_pkg::CONFIG_A;
        end
        else if (currentConfig >= configurationSelect)
        begin
            // Last configuration of the set, wrap around
            nextConfig = rcmc_pkg::CONFIG_A;
        end
        else
        begin
            nextConfig = currentConfig + 2'h1;
        end
    end

endmodule : rcmc_resume_select

//--- logic/rcmc_control.sv
// Function
// - Gain freeze command pulses when host-sourced
// - Frequency freeze command pulses when host-sourced
// - Forced timeout under external processing
// - Forced message end under external processing
// - Message end resumes at A or next
// - Timeout resumes at A or next channel
// - Single channel: timeout advances configuration
// - Cycle start clears FIFO in slave
// - Wake-up clears FIFO in self polling
// - Frame start clears FIFO, default enabled
// - Lock FIFO on message end
// - Halt receive chain while locked
// - Crystal precision kept in sleep
// - Mode select: slave/sleep or polling
// - Configuration select bounds polling set
//
// Chosen here: the strobed register port.
module rcmc_control (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Host register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regReadData,
    // Settings held elsewhere in the device
    input wire logic gainFreezeSource,
    input wire logic freqFreezeSource,
    input wire logic [1:0] externalProcessingSelect,
    input wire logic operatingModeSelect,
    input wire logic [1:0] configurationSelect,
    input wire logic singleChannel,
    // Receive chain events
    input wire logic receiveTimeoutIn,
    input wire logic messageEndIn,
    input wire logic slaveCycleStart,
    input wire logic wakeupFound,
    input wire logic frameStart,
    input wire logic fifoLockRelease,
    // Polling sequencer position
    input wire logic pollRunActive,
    input wire logic [1:0] currentConfig,
    // Freeze commands
    output logic manualGainFreeze,
    output logic manualFreqFreeze,
    // Event outputs
    output logic receiveTimeoutEvent,
    output logic messageEndEvent,
    // FIFO control
    output logic fifoClear,
    output logic fifoLocked,
    output logic rxChainHalt,
    // Polling resume decision
    output logic resumeStrobe,
    output logic [1:0] resumeConfig,
    output logic resumeNextChannel,
    // Oscillator
    output logic crystalPrecisionInSleep
);

    // All state of the block in one word
    typedef struct packed {
        logic [rcmc_pkg::MODE_BITS-1:0] modeCtrl;
        logic [7:0] readData;
        logic gainFreeze;
        logic freqFreeze;
        logic timeout;
        logic msgEnd;
        logic fifoClr;
        logic resume;
        logic [1:0] resumeCfg;
        logic resumeChannel;
        rcmc_pkg::rcmc_lock_t lock;
    } rcmc_state_t;

    rcmc_state_t state_q;
    rcmc_state_t state_d;

    // Decoded strobes
    logic cmdWrite;
    logic modeWrite;
    logic externalMode;
    logic forcedTimeout;
    logic forcedMsgEnd;
    logic timeoutNow;
    logic msgEndNow;
    logic selfPolling;
    logic resumeFromMsg;
    logic resumeFromTimeout;
    logic advanceConfig;
    logic [1:0] nextConfig;

    // Address match, used for both strobes and the read mux
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
        hit = (addr == offset);
    endfunction : hit

    assign cmdWrite = regWrite && hit(regAddr, rcmc_pkg::CMD_OFFSET);
    assign modeWrite = regWrite && hit(regAddr, rcmc_pkg::MODE_OFFSET);

    // Operating mode bit tells slave/sleep apart from polling
    // mode select decode
    assign selfPolling = (operatingModeSelect == rcmc_pkg::MODE_SELF_POLL);

    // Forcing only applies while data processing is done outside
    assign externalMode = (externalProcessingSelect == rcmc_pkg::EXT_PROC_ONE)
        || (externalProcessingSelect == rcmc_pkg::EXT_PROC_TWO);

    assign forcedTimeout = cmdWrite && externalMode
        && regWriteData[rcmc_pkg::CMD_TIMEOUT_BIT];
    assign forcedMsgEnd = cmdWrite && externalMode
        && regWriteData[rcmc_pkg::CMD_MSG_END_BIT];

    // Forced events merge with the internally detected ones
    assign timeoutNow = receiveTimeoutIn || forcedTimeout;
    assign msgEndNow = messageEndIn || forcedMsgEnd;

    // Resume decisions only count while running out of self polling
    assign resumeFromMsg = selfPolling && pollRunActive && msgEndNow;
    assign resumeFromTimeout = selfPolling && pollRunActive && timeoutNow && !msgEndNow;

    assign advanceConfig = resumeFromMsg
        ? state_q.modeCtrl[rcmc_pkg::MODE_NEXT_CFG_BIT]
        : (state_q.modeCtrl[rcmc_pkg::MODE_NEXT_CH_BIT] && singleChannel);

    rcmc_resume_select resumeSelect (
        .currentConfig(currentConfig),
        .configurationSelect(configurationSelect),
        .advance(advanceConfig),
        .nextConfig(nextConfig)
    );

    // Next-state logic for the whole block
    always_comb
    begin
        state_d = state_q;

        if (modeWrite)
        begin
            state_d.modeCtrl = regWriteData[rcmc_pkg::MODE_BITS-1:0];
        end

        // Read data valid only in the cycle after the strobe
        state_d.readData = 8'h00;
        if (regRead && hit(regAddr, rcmc_pkg::MODE_OFFSET))
        begin
            state_d.readData = {2'h0, state_q.modeCtrl};
        end
        // command register reads zero
        // Command reads and unmapped reads leave zero

        state_d.gainFreeze = cmdWrite && gainFreezeSource
            && regWriteData[rcmc_pkg::CMD_GAIN_FREEZE_BIT];
        state_d.freqFreeze = cmdWrite && freqFreezeSource
            && regWriteData[rcmc_pkg::CMD_FREQ_FREEZE_BIT];

        // one pulse per write
        // Event outputs are single-cycle, so a repeated write retriggers
        state_d.timeout = timeoutNow;
        state_d.msgEnd = msgEndNow;

        // FIFO clear sources
        state_d.fifoClr = 1'h0;
        if (state_q.modeCtrl[rcmc_pkg::MODE_CYCLE_CLR_BIT] && !selfPolling && slaveCycleStart)
        begin
            state_d.fifoClr = 1'h1;
        end
        if (state_q.modeCtrl[rcmc_pkg::MODE_CYCLE_CLR_BIT] && selfPolling && wakeupFound)
        begin
            state_d.fifoClr = 1'h1;
        end
        if (state_q.modeCtrl[rcmc_pkg::MODE_FRAME_CLR_BIT] && frameStart)
        begin
            state_d.fifoClr = 1'h1;
        end

        // Lock: a message end in the release cycle keeps the lock while the lock bit is set
        unique case (state_q.lock)
            rcmc_pkg::LK_FREE:
            begin
                if (state_q.modeCtrl[rcmc_pkg::MODE_LOCK_BIT] && msgEndNow)
                begin
                    state_d.lock = rcmc_pkg::LK_HELD;
                end
            end
            rcmc_pkg::LK_HELD:
            begin
                // Set wins over release
                if (fifoLockRelease
                    && !(state_q.modeCtrl[rcmc_pkg::MODE_LOCK_BIT] && msgEndNow))
                begin
                    state_d.lock = rcmc_pkg::LK_FREE;
                end
            end
        endcase

        // Resume decision, message end takes priority over timeout
        state_d.resume = resumeFromMsg || resumeFromTimeout;
        state_d.resumeCfg = rcmc_pkg::CONFIG_A;
        state_d.resumeChannel = 1'h0;
        if (resumeFromMsg)
        begin
            state_d.resumeCfg = nextConfig;
        end
        else if (resumeFromTimeout)
        begin
            state_d.resumeCfg = nextConfig;
            state_d.resumeChannel = state_q.modeCtrl[rcmc_pkg::MODE_NEXT_CH_BIT]
                && !singleChannel;
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= '{
                modeCtrl: rcmc_pkg::MODE_RESET,
                readData: rcmc_pkg::CMD_RESET,
                gainFreeze: 1'h0,
                freqFreeze: 1'h0,
                timeout: 1'h0,
                msgEnd: 1'h0,
                fifoClr: 1'h0,
                resume: 1'h0,
                resumeCfg: rcmc_pkg::CONFIG_A,
                resumeChannel: 1'h0,
                lock: rcmc_pkg::LK_FREE
            };
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Outputs straight from the state word
    assign regReadData = state_q.readData;
    assign manualGainFreeze = state_q.gainFreeze;
    assign manualFreqFreeze = state_q.freqFreeze;
    assign receiveTimeoutEvent = state_q.timeout;
    assign messageEndEvent = state_q.msgEnd;
    assign fifoClear = state_q.fifoClr;
    assign fifoLocked = logic'(state_q.lock);
    assign rxChainHalt = logic'(state_q.lock);
    assign resumeStrobe = state_q.resume;
    assign resumeConfig = state_q.resumeCfg;
    assign resumeNextChannel = state_q.resumeChannel;
    assign crystalPrecisionInSleep = state_q.modeCtrl[rcmc_pkg::MODE_XTAL_BIT];

    // Checks on the block's own outputs
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_gain_freeze: assert property (
        cmdWrite && gainFreezeSource && regWriteData[rcmc_pkg::CMD_GAIN_FREEZE_BIT]
        |=> manualGainFreeze)
        else $error("gain freeze not issued");
    a_freq_freeze: assert property (
        manualFreqFreeze |-> $past(cmdWrite && freqFreezeSource
            && regWriteData[rcmc_pkg::CMD_FREQ_FREEZE_BIT]))
        else $error("spurious frequency freeze");
    a_forced_timeout: assert property (
        cmdWrite && regWriteData[rcmc_pkg::CMD_TIMEOUT_BIT] && externalMode
        |=> receiveTimeoutEvent)
        else $error("forced timeout missing");
    a_msg_end_cause: assert property (
        messageEndEvent |-> $past(messageEndIn
            || (cmdWrite && regWriteData[rcmc_pkg::CMD_MSG_END_BIT] && externalMode)))
        else $error("message end without cause");
    a_cmd_reads_zero: assert property (
        regRead && regAddr == rcmc_pkg::CMD_OFFSET |=> regReadData == 8'h00)
        else $error("command register read nonzero");
    a_unused_zero: assert property (
        regRead && regAddr == rcmc_pkg::MODE_OFFSET |=> regReadData[7:6] == 2'h0)
        else $error("unused bits read nonzero");
    a_resume_config_a: assert property (
        selfPolling && pollRunActive && msgEndNow
        && !state_q.modeCtrl[rcmc_pkg::MODE_NEXT_CFG_BIT]
        |=> resumeStrobe && resumeConfig == rcmc_pkg::CONFIG_A)
        else $error("resume not at first configuration");
    a_lock_halt: assert property (
        state_q.modeCtrl[rcmc_pkg::MODE_LOCK_BIT] && msgEndNow |=> fifoLocked && rxChainHalt)
        else $error("lock not applied on message end");
    a_lock_holds: assert property (
        fifoLocked && !fifoLockRelease |=> fifoLocked && rxChainHalt)
        else $error("lock dropped without release");
    a_frame_clear: assert property (
        frameStart && state_q.modeCtrl[rcmc_pkg::MODE_FRAME_CLR_BIT] |=> fifoClear)
        else $error("frame start clear missing");

endmodule : rcmc_control

//--- verification/rcmc_control_test.sv
module rcmc_control_test;
    timeunit 1ns;
    timeprecision 1ps;

    // Clock, reset and host port
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWriteData = 8'h00;
    logic regWrite = 1'b0, regRead = 1'b0;
    // Settings and events, all driven from the random stream
    logic gainFreezeSource = 1'b0, freqFreezeSource = 1'b0, operatingModeSelect = 1'b0;
    logic [1:0] externalProcessingSelect = 2'h0, configurationSelect = 2'h0;
    logic [1:0] currentConfig = 2'h0;
    logic singleChannel = 1'b0, receiveTimeoutIn = 1'b0, messageEndIn = 1'b0;
    logic slaveCycleStart = 1'b0, wakeupFound = 1'b0, frameStart = 1'b0;
    logic fifoLockRelease = 1'b0, pollRunActive = 1'b0;
    // Design outputs
    logic [7:0] regReadData;
    logic manualGainFreeze, manualFreqFreeze, receiveTimeoutEvent, messageEndEvent;
    logic fifoClear, fifoLocked, rxChainHalt, resumeStrobe, resumeNextChannel;
    logic [1:0] resumeConfig;
    logic crystalPrecisionInSleep;
    // Model state and expected outputs
    int mMode = 4, mLock = 0, eRd = 0, eGain = 0, eFreq = 0, eTo = 0, eEom = 0;
    int eClr = 0, eRes = 0, eCfg = 0, eNch = 0, eXtal = 0, cmdWr, extOk, nxt;
    int errCount = 0;
    int samplesChecked = 0;
    int seed = 32'h7902;
    logic [31:0] r, s;

    // Free-running 100 MHz clock
    always #5 clk = ~clk;

    rcmc_control dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWriteData(regWriteData),
        .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
        .gainFreezeSource(gainFreezeSource), .freqFreezeSource(freqFreezeSource),
        .externalProcessingSelect(externalProcessingSelect),
        .operatingModeSelect(operatingModeSelect), .configurationSelect(configurationSelect),
        .singleChannel(singleChannel), .receiveTimeoutIn(receiveTimeoutIn),
        .messageEndIn(messageEndIn), .slaveCycleStart(slaveCycleStart),
        .wakeupFound(wakeupFound), .frameStart(frameStart), .fifoLockRelease(fifoLockRelease),
        .pollRunActive(pollRunActive), .currentConfig(currentConfig),
        .manualGainFreeze(manualGainFreeze), .manualFreqFreeze(manualFreqFreeze),
        .receiveTimeoutEvent(receiveTimeoutEvent), .messageEndEvent(messageEndEvent),
        .fifoClear(fifoClear), .fifoLocked(fifoLocked), .rxChainHalt(rxChainHalt),
        .resumeStrobe(resumeStrobe), .resumeConfig(resumeConfig),
        .resumeNextChannel(resumeNextChannel),
        .crystalPrecisionInSleep(crystalPrecisionInSleep));

    // Compare one result and count it
    task automatic chk(input string name, input int expVal, input logic [7:0] got);
        samplesChecked++;
        if (got !== expVal[7:0])
        begin
            errCount++;
            $display("BAD %s expected %h seen %h", name, expVal[7:0], got);
        end
    endtask : chk

    // Single exit point for both normal end and watchdog
    task automatic end_sim();
        if (errCount == 0 && samplesChecked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim

    // Reference model: sees the inputs as the design samples them at the edge
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            // Mode register comes back with frame-start clearing enabled
            mMode = 4;
            mLock = 0;
            {eRd, eGain, eFreq, eTo, eEom, eClr, eRes, eCfg, eNch, eXtal} = '0;
        end
        else
        begin
            cmdWr = regWrite && regAddr == rcmc_pkg::CMD_OFFSET;
            extOk = externalProcessingSelect == 2'h1 || externalProcessingSelect == 2'h2;
            // command reads zero, mode upper bits zero
            eRd = (regRead && regAddr == rcmc_pkg::MODE_OFFSET) ? mMode : 0;
            eGain = cmdWr && regWriteData[3] && gainFreezeSource;
            eFreq = cmdWr && regWriteData[2] && freqFreezeSource;
            eTo = receiveTimeoutIn || (cmdWr && regWriteData[1] && extOk);
            eEom = messageEndIn || (cmdWr && regWriteData[0] && extOk);
            eClr = (mMode[3] && slaveCycleStart && !operatingModeSelect)
                || (mMode[3] && wakeupFound && operatingModeSelect) || (mMode[2] && frameStart);
            // resume decision, wraps after the last config
            nxt = (currentConfig == configurationSelect) ? 0 : currentConfig + 1;
            eRes = operatingModeSelect && pollRunActive && (eTo || eEom);
            eCfg = eEom ? (mMode[5] ? nxt : 0) : ((mMode[4] && singleChannel) ? nxt : 0);
            eNch = !eEom && mMode[4] && !singleChannel;
            // set wins over a release in the same cycle
            if (eEom && mMode[1])
                mLock = 1;
            else if (fifoLockRelease)
                mLock = 0;
            // Mode write lands after this edge's decisions
            if (regWrite && regAddr == rcmc_pkg::MODE_OFFSET)
                mMode = regWriteData[5:0];
            eXtal = mMode[0];
        end
    end

    // Compare on the falling edge, where outputs have settled
    always @(negedge clk)
    begin
        chk("regReadData", eRd, regReadData);
        chk("manualGainFreeze", eGain, {7'h0, manualGainFreeze});
        chk("manualFreqFreeze", eFreq, {7'h0, manualFreqFreeze});
        chk("receiveTimeoutEvent", eTo, {7'h0, receiveTimeoutEvent});
        chk("messageEndEvent", eEom, {7'h0, messageEndEvent});
        chk("fifoClear", eClr, {7'h0, fifoClear});
        chk("fifoLocked", mLock, {7'h0, fifoLocked});
        chk("rxChainHalt", mLock, {7'h0, rxChainHalt});
        chk("crystalPrecisionInSleep", eXtal, {7'h0, crystalPrecisionInSleep});
        chk("resumeStrobe", eRes, {7'h0, resumeStrobe});
        // Resume details only mean something beside the strobe
        if (eRes != 0)
        begin
            chk("resumeConfig", eCfg, {6'h0, resumeConfig});
            chk("resumeNextChannel", eNch, {7'h0, resumeNextChannel});
        end
    end

    // Two passes, each starting from reset, the second one a mid-run reset
    initial
    begin
        for (int p = 0; p < 2; p++)
        begin
            rst <= 1'b1;
            regWrite <= 1'b0;
            regRead <= 1'b0;
            repeat (16) @(posedge clk);
            rst <= 1'b0;
            @(posedge clk);
            // First access reads the mode register reset value
            regRead <= 1'b1;
            regAddr <= rcmc_pkg::MODE_OFFSET;
            for (int i = 0; i < 1500; i++)
            begin
                @(posedge clk);
                r = $random(seed);
                s = $random(seed);
                // Strobes never together; addresses favour the two registers
                regWrite <= r[1:0] == 2'h0;
                regRead <= r[1:0] == 2'h1;
                regAddr <= (r[3:2] == 2'h0) ? r[15:8] :
                    (r[2] ? rcmc_pkg::CMD_OFFSET : rcmc_pkg::MODE_OFFSET);
                regWriteData <= r[23:16];
                gainFreezeSource <= s[0];
                freqFreezeSource <= s[1];
                externalProcessingSelect <= s[3:2];
                operatingModeSelect <= s[4];
                configurationSelect <= s[6:5];
                // Active config always lies inside the polling set
                currentConfig <= (s[8:7] > s[6:5]) ? s[6:5] : s[8:7];
                singleChannel <= s[9];
                receiveTimeoutIn <= s[12:10] == 3'h0;
                messageEndIn <= s[15:13] == 3'h0;
                // Cycle start and wake-up in either mode, so the mode gating is exercised
                slaveCycleStart <= s[17:16] == 2'h0;
                wakeupFound <= s[17:16] == 2'h1;
                frameStart <= s[19:18] == 2'h0;
                // Rare release so locks are seen to hold
                fifoLockRelease <= s[22:20] == 3'h0;
                pollRunActive <= s[23] | s[24];
            end
        end
        @(posedge clk);
        @(posedge clk);
        end_sim();
    end

    // Watchdog well beyond the expected run of about 3040 cycles
    initial
    begin
        #100us;
        errCount++;
        end_sim();
    end

endmodule : rcmc_control_test
